//--- design/cdd_pkg.sv
// Constants, register map and helpers for the clock and sync reference divider/delay block.
// Assumes one clock domain (ref_clk) standing in for the device input clock.
package cdd_pkg;
	localparam int NCH = 4;
	localparam int NREF = 8;
	localparam int REF_PER_CH = 2;
	localparam int DIV_W = 4;
	localparam int CDLY_W = 8;
	localparam int CDLY_STEPS = 256;
	localparam int RDLY_W = 3;
	localparam int RDLY_MAX = 7;
	localparam int MULT_MAX = 4;
	localparam int RLINE_W = RDLY_MAX * MULT_MAX + 1;
	localparam int PHASE_W = 6;
	localparam logic [PHASE_W-1:0] PHASE_LAST = 6'd47; // Last phase; the 48-count cycle is a common multiple of all ratios
	localparam logic [DIV_W-1:0] DIV_BYPASS = 4'h0;
	localparam logic [DIV_W-1:0] DIV_BY3 = 4'h2;
	localparam logic [DIV_W-1:0] DIV_BY4 = 4'h3;
	localparam logic [DIV_W-1:0] DIV_CODE_MAX = 4'h8;
	// Register byte addresses
	localparam int ADDR_W = 8;
	localparam logic [ADDR_W-1:0] REG_DIV = 8'h00;
	localparam logic [ADDR_W-1:0] REG_CDLY = 8'h04;
	localparam logic [ADDR_W-1:0] REG_RDLY = 8'h08;
	localparam logic [ADDR_W-1:0] REG_CTRL = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_STAT = 8'h10;
	// Control register fields
	localparam int CTRL_MULT_LSB = 0;
	localparam int CTRL_CAL_BIT = 4;
	localparam int CTRL_PD_LSB = 8;
	localparam int CTRL_REN_LSB = 16;
	// Status register fields
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;
	localparam int STAT_UNIT_LSB = 4;
	localparam int STAT_LOADED_BIT = 8;
	localparam logic [31:0] DIV_RESET = 32'h0000_0000;
	localparam logic [1:0] RESP_OK = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Serial frame: one read flag, seven index bits, 32 data bits
	localparam int SPI_HDR_BITS = 8;
	localparam logic [5:0] SPI_LAST_BIT = 6'd39;
	localparam int CAL_CYCLES_DEF = 1024;

	// Divider code to ratio; unknown codes fall back to bypass
	function automatic logic [PHASE_W-1:0] div_ratio(input logic [DIV_W-1:0] code);
		unique case (code)
			4'h1: div_ratio = 6'd2;
			4'h2: div_ratio = 6'd3;
			4'h3: div_ratio = 6'd4;
			4'h4: div_ratio = 6'd6;
			4'h5: div_ratio = 6'd8;
			4'h6: div_ratio = 6'd12;
			4'h7: div_ratio = 6'd16;
			4'h8: div_ratio = 6'd24;
			default: div_ratio = 6'd1;
		endcase
	endfunction
endpackage

//--- design/cdd_chan_if.sv
// Bundle between the register core and one clock channel.
// Assumes the phase count is shared by all channels of one core.
`timescale 1ns/100ps
interface cdd_chan_if;
	import cdd_pkg::*;
	logic [DIV_W-1:0] div_code;
	logic [CDLY_W-1:0] clk_dly;
	logic pwr_dn;
	logic [PHASE_W-1:0] phase;
	logic chan_out;
	modport ctl (output div_code, output clk_dly, output pwr_dn, output phase, input chan_out);
	modport chan (input div_code, input clk_dly, input pwr_dn, input phase, output chan_out);
endinterface

//--- design/cdd_chan.sv
// One clock channel: divider, input-period delay line and power-down.
// Assumes the phase count wraps at a multiple of every ratio.
`timescale 1ns/100ps
module cdd_chan
	import cdd_pkg::*;
(
	input wire logic ref_clk, // Device clock
	input wire logic arst_n, // Async reset, low
	cdd_chan_if.chan cif // Settings in, channel clock out
);
	typedef struct packed {
		logic [DIV_W-1:0] div;
		logic [CDLY_W-1:0] dly;
		logic pd;
		logic [CDLY_STEPS-1:0] line;
		logic out;
	} cdd_chs_s;

	cdd_chs_s st_q;
	cdd_chs_s st_d;
	logic [PHASE_W-1:0] ratio;
	logic base;

	// ==========================================================
	// Divider and delay
	// Edge strobe: one cycle high on each divided incident edge
	always_comb begin
		st_d = st_q;
		ratio = div_ratio(st_q.div);
		// All ratios key off one shared count, so edges line up
		base = (cif.phase % ratio) == '0;
		// Settings change only where every ratio has an edge
		if (cif.phase == '0) begin
			st_d.div = cif.div_code;
			st_d.dly = cif.clk_dly;
			st_d.pd = cif.pwr_dn;
		end
		st_d.line = {st_q.line[CDLY_STEPS-2:0], base};
		// Delay counted in whole input periods
		st_d.out = st_q.pd ? 1'b0 : st_d.line[st_q.dly];
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign cif.chan_out = st_q.out;
endmodule

//--- design/cdd_top.sv
// Register core, sync reference delay, calibration sequencer and host ports.
// Assumes ref_clk is the device input clock; pins and serial lines are asynchronous.
`timescale 1ns/100ps
module cdd_top
	import cdd_pkg::*;
#(
	parameter int CAL_CYCLES = CAL_CYCLES_DEF
)(
	input wire logic ref_clk, // Device clock
	input wire logic arst_n, // Async reset, low
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Byte enables
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic spi_sclk, // Serial clock pin
	input wire logic serial_select_low, // Serial select, low
	input wire logic serial_data_line_i, // Serial data in
	output logic serial_data_line_o, // Serial data out
	output logic serial_data_line_oe, // Serial data drive enable
	input wire logic sync_reference_input, // Sync reference in
	input wire logic mid_channel_divider_strap, // Middle channel default strap
	output logic [NCH-1:0] channel_clock_output, // Channel edge strobes
	output logic [NREF-1:0] sync_reference_output, // Delayed references
	output logic calibration_oscillator_en // Delay oscillator running
);
	typedef struct packed {
		logic [2:0] pin_s1; // First sync stage: sclk, select, data
		logic [2:0] pin_s2;
		logic sclk_prev;
		logic strap_s1;
		logic strap_s2;
		logic [1:0] load_cnt;
		logic loaded;
		logic ref_s1;
		logic ref_s2;
		logic [RLINE_W-1:0] ref_line;
		logic [NREF-1:0] ref_out;
		logic [PHASE_W-1:0] phase;
		logic [31:0] div;
		logic [31:0] cdly;
		logic [31:0] rdly;
		logic [1:0] mult;
		logic cal_go;
		logic [NCH-1:0] pd;
		logic [NREF-1:0] ren;
		logic cal_busy;
		logic cal_done;
		logic [15:0] cal_cnt;
		logic [1:0] cal_mult;
		logic aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [5:0] bit_cnt;
		logic [SPI_HDR_BITS-1:0] hdr;
		logic [31:0] sh;
		logic sdo;
		logic sdo_oe;
		logic spi_wr;
		logic [31:0] spi_data;
	} cdd_st_s;

	cdd_st_s st_q;
	cdd_st_s st_d;
	logic sclk_rise;
	logic sclk_fall;
	logic sel_act;
	logic axi_wr;
	logic [31:0] spi_word;

	// ==========================================================
	// Known limits
	// Serial clock half periods below four clocks lose bits
	// Select, serial clock and data each lag two clocks behind the pins
	// Only six index bits reach the byte address; higher indexes alias
	// Reference delay unit is one to four clocks here, not a trimmed time step
	// Calibration run is a fixed count, it does not model a lock
	// A pending serial write holds off bus writes until it lands
	// Status writes answer okay and leave the status alone
	// Reference outputs stay off until software enables them
	// Strap is read once after reset; later pin changes are ignored
	// Divider and delay changes wait for the next common phase zero
	// A new setting can thus take up to 48 clocks to appear

	// ==========================================================
	// Register helpers
	// Mapped test works on byte addresses
	function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
		reg_hit = (a == REG_DIV) || (a == REG_CDLY) || (a == REG_RDLY)
			|| (a == REG_CTRL) || (a == REG_STAT);
	endfunction

	// Read view of the map, status shows live block state
	function automatic logic [31:0] reg_rd(input cdd_st_s s, input logic [ADDR_W-1:0] a);
		reg_rd = '0;
		unique case (a)
			REG_DIV: reg_rd = s.div;
			REG_CDLY: reg_rd = s.cdly;
			REG_RDLY: reg_rd = s.rdly;
			REG_CTRL: begin
				reg_rd[CTRL_MULT_LSB +: 2] = s.mult;
				reg_rd[CTRL_CAL_BIT] = s.cal_go;
				reg_rd[CTRL_PD_LSB +: NCH] = s.pd;
				reg_rd[CTRL_REN_LSB +: NREF] = s.ren;
			end
			REG_STAT: begin
				reg_rd[STAT_BUSY_BIT] = s.cal_busy;
				reg_rd[STAT_DONE_BIT] = s.cal_done;
				reg_rd[STAT_UNIT_LSB +: 2] = s.cal_mult;
				reg_rd[STAT_LOADED_BIT] = s.loaded;
			end
			default: reg_rd = '0;
		endcase
	endfunction

	// Byte-lane merge then field update; status is read only
	function automatic cdd_st_s reg_wr(input cdd_st_s s, input logic [ADDR_W-1:0] a,
		input logic [31:0] d, input logic [3:0] strb);
		logic [31:0] m;
		logic [31:0] v;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		v = (reg_rd(s, a) & ~m) | (d & m);
		reg_wr = s;
		unique case (a)
			REG_DIV: reg_wr.div = v;
			REG_CDLY: reg_wr.cdly = v;
			REG_RDLY: reg_wr.rdly = v;
			REG_CTRL: begin
				reg_wr.mult = v[CTRL_MULT_LSB +: 2];
				// Only a one starts; software cannot abort a run
				reg_wr.cal_go = s.cal_go | v[CTRL_CAL_BIT];
				reg_wr.pd = v[CTRL_PD_LSB +: NCH];
				reg_wr.ren = v[CTRL_REN_LSB +: NREF];
			end
			default: reg_wr = s;
		endcase
	endfunction

	// ==========================================================
	// Next-state logic
	always_comb begin
		st_d = st_q;
		// Pins pass two flops before any logic looks at them
		st_d.pin_s1 = {spi_sclk, serial_select_low, serial_data_line_i};
		st_d.pin_s2 = st_q.pin_s1;
		st_d.sclk_prev = st_q.pin_s2[2];
		st_d.strap_s1 = mid_channel_divider_strap;
		st_d.strap_s2 = st_q.strap_s1;
		st_d.ref_s1 = sync_reference_input;
		st_d.ref_s2 = st_q.ref_s1;
		sclk_rise = st_q.pin_s2[2] && !st_q.sclk_prev;
		sclk_fall = !st_q.pin_s2[2] && st_q.sclk_prev;
		sel_act = !st_q.pin_s2[1];

		// Strap caught once the sync chain holds the real pin level
		// Bus readys wait on this, so no write can race the defaults
		if (!st_q.loaded) begin
			st_d.load_cnt = st_q.load_cnt + 2'd1;
			if (st_q.load_cnt == 2'd2) begin
				st_d.loaded = 1'b1;
				// Sync flops reset to one, but by now they hold the sampled pin level
				st_d.div[1*DIV_W +: DIV_W] = st_q.strap_s2 ? DIV_BY4 : DIV_BY3;
				st_d.div[2*DIV_W +: DIV_W] = st_q.strap_s2 ? DIV_BY4 : DIV_BY3;
				st_d.div[0*DIV_W +: DIV_W] = DIV_BYPASS;
				st_d.div[3*DIV_W +: DIV_W] = DIV_BYPASS;
			end
		end

		// Shared phase count, wraps where every ratio has an edge
		st_d.phase = (st_q.phase == PHASE_LAST) ? '0 : st_q.phase + 6'd1;

		// Calibration sequencer; the run length is a stand-in lock time
		// A start written during the last busy cycle is kept, so a
		// second run follows at once instead of being lost
		if (st_q.cal_busy) begin
			st_d.cal_cnt = st_q.cal_cnt + 16'd1;
			if (st_q.cal_cnt == 16'(CAL_CYCLES - 1)) begin
				st_d.cal_busy = 1'b0;
				st_d.cal_go = 1'b0;
				st_d.cal_done = 1'b1;
				st_d.cal_mult = st_q.mult;
			end
		end else if (st_q.cal_go) begin
			st_d.cal_busy = 1'b1;
			st_d.cal_cnt = '0;
		end

		// Reference path: its own line, untouched by divider and delay settings; channel power-down gates its pair
		// Longest tap is seven steps times four, the top of the line
		st_d.ref_line = {st_q.ref_line[RLINE_W-2:0], st_q.ref_s2};
		for (int r = 0; r < NREF; r++) begin
			// Step count scaled by the stored unit, not the live field
			st_d.ref_out[r] = st_q.ren[r] && !st_q.pd[r / REF_PER_CH]
				&& st_q.ref_line[int'(st_q.rdly[r*4 +: RDLY_W]) * (int'(st_q.cal_mult) + 1)];
		end

		// AXI write channels, either order; parked while a serial write waits
		if (s_axi_awvalid && s_axi_awready) begin
			st_d.aw_got = 1'b1;
			st_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			st_d.w_got = 1'b1;
			st_d.wdata = s_axi_wdata;
			st_d.wstrb = s_axi_wstrb;
		end
		axi_wr = st_q.aw_got && st_q.w_got && !st_q.bvalid && !st_q.spi_wr;
		if (st_q.bvalid && s_axi_bready) begin
			st_d.bvalid = 1'b0;
		end
		if (axi_wr) begin
			st_d.aw_got = 1'b0;
			st_d.w_got = 1'b0;
			st_d.bvalid = 1'b1;
			st_d.bresp = reg_hit(st_q.aw_addr) ? RESP_OK : RESP_SLVERR;
			st_d = reg_wr(st_d, st_q.aw_addr, st_q.wdata, st_q.wstrb);
		end

		// AXI read
		// Read data come from the map as it stood before this edge
		if (st_q.rvalid && s_axi_rready) begin
			st_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			st_d.rvalid = 1'b1;
			st_d.rresp = reg_hit(s_axi_araddr) ? RESP_OK : RESP_SLVERR;
			st_d.rdata = reg_rd(st_q, s_axi_araddr);
		end

		// Pending serial write lands when no bus write competes
		// Word as it stands once the last data bit comes in
		spi_word = {st_q.sh[30:0], st_q.pin_s2[0]};
		if (st_q.spi_wr && !axi_wr) begin
			st_d.spi_wr = 1'b0;
			st_d = reg_wr(st_d, {st_q.hdr[ADDR_W-3:0], 2'b00}, st_q.spi_data, 4'hF);
		end

		// Serial port: sample on rise, drive read data on fall
		// Frame: eight header bits, then thirty-two data bits, MSB first
		// Bit counter parks on the last bit until select goes away
		if (!sel_act) begin
			st_d.bit_cnt = '0;
			st_d.sdo_oe = 1'b0;
		end else if (sclk_rise) begin
			if (st_q.bit_cnt < 6'(SPI_HDR_BITS)) begin
				st_d.hdr = {st_q.hdr[SPI_HDR_BITS-2:0], st_q.pin_s2[0]};
			end else if (!st_q.sdo_oe) begin
				// During read-back only the fall edge moves the word out;
				// shifting here too would skip every second bit
				st_d.sh = {st_q.sh[30:0], st_q.pin_s2[0]};
			end
			if (st_q.bit_cnt != SPI_LAST_BIT) begin
				st_d.bit_cnt = st_q.bit_cnt + 6'd1;
			end
			// Header complete: a read loads the word and takes the line
			if (st_q.bit_cnt == 6'(SPI_HDR_BITS - 1) && st_d.hdr[SPI_HDR_BITS-1]) begin
				st_d.sh = reg_rd(st_q, {st_d.hdr[ADDR_W-3:0], 2'b00});
				st_d.sdo_oe = 1'b1;
			end
			if (st_q.bit_cnt == SPI_LAST_BIT && !st_q.hdr[SPI_HDR_BITS-1]) begin
				st_d.spi_wr = 1'b1;
				st_d.spi_data = spi_word;
			end
		end else if (sclk_fall && st_q.sdo_oe) begin
			st_d.sdo = st_q.sh[31];
			st_d.sh = {st_q.sh[30:0], 1'b0};
		end
	end

	// ==========================================================
	// State register
	// Strap and select chains reset high: pulled-up pins idle high
	// Everything else clears to zero, channel settings included
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= '0;
			st_q.strap_s1 <= 1'b1;
			st_q.strap_s2 <= 1'b1;
			st_q.pin_s1 <= 3'b010;
			st_q.pin_s2 <= 3'b010;
			st_q.div <= DIV_RESET;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================================
	// Channels
	// Each channel reads its own fields; power-down also gates it
	// One bundle per channel keeps the channel port list short
	generate
		for (genvar c = 0; c < NCH; c++) begin : g_ch
			cdd_chan_if cif ();
			assign cif.div_code = st_q.div[c*DIV_W +: DIV_W];
			assign cif.clk_dly = st_q.cdly[c*CDLY_W +: CDLY_W];
			assign cif.pwr_dn = st_q.pd[c];
			assign cif.phase = st_q.phase;
			assign channel_clock_output[c] = cif.chan_out;
			cdd_chan u_chan (
				.ref_clk(ref_clk),
				.arst_n(arst_n),
				.cif(cif)
			);
		end
	endgenerate

	// ==========================================================
	// Outputs
	// Readys stay low until the strap is loaded, so a request made
	// early after reset simply waits; none is ever dropped
	assign s_axi_awready = !st_q.aw_got && !st_q.spi_wr && st_q.loaded;
	assign s_axi_wready = !st_q.w_got && !st_q.spi_wr && st_q.loaded;
	assign s_axi_bvalid = st_q.bvalid;
	assign s_axi_bresp = st_q.bresp;
	assign s_axi_arready = !st_q.rvalid && st_q.loaded;
	assign s_axi_rvalid = st_q.rvalid;
	assign s_axi_rresp = st_q.rresp;
	assign s_axi_rdata = st_q.rdata;
	assign serial_data_line_o = st_q.sdo;
	assign serial_data_line_oe = st_q.sdo_oe && sel_act;
	assign sync_reference_output = st_q.ref_out;
	// Oscillator only runs while calibrating, quiet afterwards
	assign calibration_oscillator_en = st_q.cal_busy;
endmodule

//--- bench/cdd_top_checker.sv
// Port-level assertions for the divider/delay top module.
// Assumes one ref_clk domain and the active-low asynchronous reset.
`timescale 1ns/100ps
module cdd_top_checker
	import cdd_pkg::*;
#(
	parameter int CAL_CYCLES = CAL_CYCLES_DEF
)(
	input wire logic ref_clk, // Device clock
	input wire logic arst_n, // Reset, low
	input wire logic s_axi_awvalid, // Write address valid
	input wire logic s_axi_awready, // Write address ready
	input wire logic s_axi_wvalid, // Write data valid
	input wire logic s_axi_wready, // Write data ready
	input wire logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	input wire logic s_axi_arready, // Read address ready
	input wire logic [31:0] s_axi_rdata, // Read data
	input wire logic [1:0] s_axi_rresp, // Read response
	input wire logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic serial_select_low, // Serial select, low
	input wire logic serial_data_line_oe, // Serial drive enable
	input wire logic calibration_oscillator_en // Oscillator running
);
	logic [15:0] cnt_q;
	logic [15:0] cnt_d;
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);
	// =====================================================================
	// Oscillator run length counter
	always_comb begin
		cnt_d = calibration_oscillator_en ? cnt_q + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= 16'h0000;
		end else begin
			cnt_q <= cnt_d;
		end
	end
	// =====================================================================
	// Bus, serial line and calibration properties
	property p_wr_resp;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:8] s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write response missing");
	property p_one_wr;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_one_wr: assert property (p_one_wr) else $error("write response repeated");
	property p_rd_resp;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read data late");
	property p_one_rd;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_one_rd: assert property (p_one_rd) else $error("read data repeated");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("second read accepted");
	property p_unmapped;
		s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h13
			|=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0000_0000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
	property p_oe_idle;
		serial_select_low [*6] |-> !serial_data_line_oe;
	endproperty
	a_oe_idle: assert property (p_oe_idle) else $error("data line driven idle");
	property p_osc_len;
		$fell(calibration_oscillator_en) |-> cnt_q == 16'(CAL_CYCLES);
	endproperty
	a_osc_len: assert property (p_osc_len) else $error("oscillator run length");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_bad_read: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
	c_cal_done: cover property ($fell(calibration_oscillator_en));
endmodule

bind cdd_top cdd_top_checker #(.CAL_CYCLES(CAL_CYCLES)) i_chk (
	.ref_clk(ref_clk), .arst_n(arst_n), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.serial_select_low(serial_select_low), .serial_data_line_oe(serial_data_line_oe),
	.calibration_oscillator_en(calibration_oscillator_en)
);

//--- bench/cdd_refgen.sv
// Behavioural clock generator side: launches sync reference pulses.
// Assumes ref_clk stands for the generator's device clock output.
`timescale 1ns/100ps
module cdd_refgen (
	input wire logic ref_clk, // Clock shared with the block
	output logic sync_reference_input // Reference toward the block
);
	// Quiet until asked
	initial sync_reference_input = 1'b0;
	// Launched on clock edges so reference stays locked to the clock
	task automatic fire(input int len);
		@(posedge ref_clk);
		sync_reference_input <= 1'b1;
		repeat (len) @(posedge ref_clk);
		sync_reference_input <= 1'b0;
	endtask
endmodule

//--- bench/clock_sysref_divider_delay_tb_top.sv
// Self-checking bench: bus host, serial host and generator model around cdd_top.
// Assumes 100 MHz ref_clk and a shortened calibration run.
`timescale 1ns/100ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module clock_sysref_divider_delay_tb_top;
	import cdd_pkg::*;
	localparam int CAL = 16;
	logic ref_clk, arst_n, strap, sclk, sel_n, host_do, host_en, serial_data_line, sdo, soe, refin, osc;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr, refo;
	logic [31:0] wdata, rdata, v;
	logic [1:0] bresp, rresp, rs;
	logic [3:0] chan;
	int bad_count, num_checks, osc_cnt;
	// Released line shows the inverse so a stale value never passes
	assign serial_data_line = soe ? sdo : (host_en ? host_do : ~host_do);
	cdd_top #(.CAL_CYCLES(CAL)) i_dut (
		.ref_clk(ref_clk), .arst_n(arst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.spi_sclk(sclk), .serial_select_low(sel_n), .serial_data_line_i(serial_data_line),
		.serial_data_line_o(sdo), .serial_data_line_oe(soe), .sync_reference_input(refin),
		.mid_channel_divider_strap(strap), .channel_clock_output(chan),
		.sync_reference_output(refo), .calibration_oscillator_en(osc)
	);
	cdd_refgen i_gen (.ref_clk(ref_clk), .sync_reference_input(refin));
	// =====================================================================
	// Clock, oscillator watch and bus tasks
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (osc === 1'b1) osc_cnt++;
	end
	task automatic results;
		$display("checks=%0d mismatches=%0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic lim(input int n);
		if (n >= 50) begin
			bad_count++;
			$display("BAD t=%0t wait limit", $time);
			results();
		end
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge ref_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		r = bresp;
		bready <= 1'b0;
		lim(n);
	endtask
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge ref_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge ref_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		lim(n);
	endtask
	// Serial frame; host lets go of the line for read data bits
	task automatic spi(input logic rd, input logic [6:0] idx, input logic [31:0] wd,
			output logic [31:0] q);
		logic [39:0] f;
		f = {rd, idx, wd};
		q = 32'h0000_0000;
		sel_n <= 1'b0;
		repeat (4) @(posedge ref_clk);
		for (int i = 39; i >= 0; i--) begin
			host_do <= f[i];
			host_en <= !(rd && i < 32);
			repeat (4) @(posedge ref_clk);
			sclk <= 1'b1;
			repeat (4) @(posedge ref_clk);
			q = {q[30:0], serial_data_line};
			sclk <= 1'b0;
		end
		repeat (4) @(posedge ref_clk);
		sel_n <= 1'b1;
		host_en <= 1'b1;
		repeat (8) @(posedge ref_clk);
	endtask
	// =====================================================================
	// Scenarios
	task automatic t_reset(input logic s);
		strap <= s;
		arst_n <= 1'b0;
		repeat (10) @(posedge ref_clk);
		arst_n <= 1'b1;
		repeat (10) @(posedge ref_clk);
		axr(REG_DIV, v, rs);
		`CHK(v, s ? 32'h0000_0330 : 32'h0000_0220)
	endtask
	task automatic t_bus;
		axw(8'h40, 32'h0000_00FF, rs);
		`CHK(rs, RESP_SLVERR)
		axr(8'h40, v, rs);
		`CHK({rs, v}, {RESP_SLVERR, 32'h0000_0000})
		axw(REG_RDLY, 32'h7654_3210, rs);
		axr(REG_RDLY, v, rs);
		`CHK(v, 32'h7654_3210)
	endtask
	task automatic t_div;
		int rt[10] = '{1, 2, 3, 4, 6, 8, 12, 16, 24, 1};
		logic [31:0] hits;
		for (int c = 0; c < 10; c++) begin
			axw(REG_DIV, 32'(c), rs);
			repeat (100) @(posedge ref_clk);
			hits = 0;
			repeat (48) begin
				@(posedge ref_clk);
				hits += 32'(chan[0]);
			end
			`CHK(hits, 32'(48 / rt[c]))
		end
	endtask
	// Ratio 2 and 4 share edges; delayed copy and powered-down channel
	task automatic t_sync;
		logic [7:0] h;
		logic [31:0] miss, hits;
		axw(REG_DIV, 32'h0000_0331, rs);
		axw(REG_CDLY, 32'h0005_0000, rs);
		axw(REG_CTRL, 32'h0000_0800, rs);
		repeat (150) @(posedge ref_clk);
		h = 8'h00;
		miss = 0;
		hits = 0;
		for (int i = 0; i < 101; i++) begin
			@(posedge ref_clk);
			h = {h[6:0], chan[1]};
			if (i >= 5) begin
				hits += 32'(chan[1]);
				miss += 32'(chan[1] && !chan[0]);
				miss += 32'(chan[2] !== h[5]);
				miss += 32'(chan[3]);
			end
		end
		`CHK(hits, 32'd24)
		`CHK(miss, 32'h0000_0000)
	endtask
	task automatic t_spi;
		logic [31:0] q;
		spi(1'b0, 7'h01, 32'h1234_5678, q);
		axr(REG_CDLY, v, rs);
		`CHK(v, 32'h1234_5678)
		spi(1'b1, 7'h01, 32'h0000_0000, q);
		`CHK(q, 32'h1234_5678)
	endtask
	task automatic t_cal;
		int n;
		osc_cnt = 0;
		axw(REG_CTRL, 32'h0000_0012, rs);
		for (n = 0; n < 50; n++) begin
			axr(REG_STAT, v, rs);
			if (v[0] === 1'b0) break;
		end
		lim(n);
		`CHK(osc_cnt, CAL)
		`CHK(v[5:0], 6'h22)
		axr(REG_CTRL, v, rs);
		`CHK(v[4], 1'b0)
	endtask
	// Stored multiplier x3: step 3 lands nine cycles after step 0
	task automatic t_ref;
		int t[3];
		axw(REG_RDLY, 32'h0000_0033, rs);
		axw(REG_CTRL, 32'h0007_0002, rs);
		t = '{0, 0, 0};
		fork
			i_gen.fire(20);
			for (int k = 1; k < 80; k++) begin
				@(posedge ref_clk);
				for (int r = 0; r < 3; r++) begin
					if (refo[r] === 1'b1 && t[r] == 0) t[r] = k;
				end
			end
		join
		`CHK(t[0] - t[1], 0)
		`CHK(t[0] - t[2], 9)
	endtask
	initial begin
		{arst_n, strap, sclk, host_do, awvalid, wvalid, bready, arvalid, rready} = '0;
		{sel_n, host_en} = 2'b11;
		{awaddr, araddr, wdata} = '0;
		t_reset(1'b0);
		t_reset(1'b1);
		t_bus();
		t_div();
		t_sync();
		t_spi();
		t_cal();
		t_ref();
		results();
	end
endmodule
